// ### logic/dso_status_out.sv
/*
 * Status-output block: arrival, overload and PID deviation detectors,
 * two assignable active-low terminals with on/off delays, APB registers.
 * Measurement inputs come from logic on core_clk_in; APB on the same clock.
 */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module dso_status_out import dso_pkg::*; #(
	parameter int unsigned FA_DLY = FA_DELAY_CYC,
	parameter int unsigned TICK_CYC = DLY_TICK_CYC
) (
	input wire logic core_clk_in, // 50 MHz
	input wire logic sys_rst_in, // sync, active high
	input wire dso_meas_s meas_in, // live drive quantities
	input wire dso_apb_req_s apb_in, // apb request
	output logic pready_out, // apb ready
	output logic [31:0] prdata_out, // apb read data
	output logic pslverr_out, // apb error
	output logic [1:0] status_n_out, // terminals, low pulls
	output logic irq_out // level interrupt
);
	typedef struct packed {
		logic [15:0] target;
		logic [15:0] acc_th;
		logic [15:0] dec_th;
		logic [15:0] ol_lvl;
		logic [15:0] dev_lvl;
		logic [1:0][2:0] sel;
		logic [1:0][9:0] on_dly;
		logic [1:0][9:0] off_dly;
		logic [1:0] fa_raw;
		logic [1:0][21:0] fa_cnt;
		logic [1:0] fa_q;
		logic ol;
		logic od;
		logic [22:0] tick_cnt;
		logic tick;
		logic [1:0][9:0] t_cnt;
		logic [1:0] term;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [31:0] prdata;
		logic pslverr;
	} dso_state_s;

	localparam dso_state_s RST_STATE = '{
		target: TARGET_RST, acc_th: ACC_TH_RST, dec_th: DEC_TH_RST,
		ol_lvl: OL_LVL_RST, dev_lvl: DEV_LVL_RST, default: '0};

	dso_state_s r;
	dso_state_s next_r;
	logic [15:0] fa1_dist;
	logic [15:0] pid_err;
	logic [1:0] fn_val;
	logic wr_acc;
	logic rd_setup;
	logic [3:0] irq_set;

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a >= b) ? (a - b) : (b - a);
	endfunction

	// distances and per-terminal function select
	always_comb begin
		fa1_dist = abs_diff(meas_in.out_freq, r.target);
		pid_err = abs_diff(meas_in.setpoint, meas_in.feedback);
		for (int i = 0; i < 2; i++) begin
			case (r.sel[i])
				OPT_FA1: fn_val[i] = r.fa_q[0];
				OPT_FA2: fn_val[i] = r.fa_q[1];
				OPT_OL: fn_val[i] = r.ol;
				OPT_OD: fn_val[i] = r.od;
				default: fn_val[i] = 1'b0;
			endcase
		end
		wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
		rd_setup = apb_in.psel && !apb_in.penable;
	end

	// next state of the whole block
	always_comb begin
		next_r = r;
		irq_set = '0;
		// constant-speed arrival with band hysteresis
		if (!meas_in.motor_on || meas_in.accel || meas_in.decel) begin
			next_r.fa_raw[0] = 1'b0;
		end else if (fa1_dist <= ARR_LEAD) begin
			next_r.fa_raw[0] = 1'b1;
		end else if (fa1_dist > ARR_LEAD + ARR_LAG) begin
			next_r.fa_raw[0] = 1'b0;
		end
		// over-frequency arrival, otherwise holds
		if (!meas_in.motor_on) begin
			next_r.fa_raw[1] = 1'b0;
		end else if (!meas_in.decel && (17'(meas_in.out_freq) + 17'(ARR_LEAD) >= 17'(r.acc_th))) begin
			next_r.fa_raw[1] = 1'b1;
		end else if (!meas_in.accel && (17'(meas_in.out_freq) + 17'(ARR_LAG) < 17'(r.dec_th))) begin
			next_r.fa_raw[1] = 1'b0;
		end
		// 60 ms settle before an arrival output follows
		for (int i = 0; i < 2; i++) begin
			if (r.fa_raw[i] == r.fa_q[i]) begin
				next_r.fa_cnt[i] = '0;
			end else if (r.fa_cnt[i] >= 22'(FA_DLY - 1)) begin
				next_r.fa_cnt[i] = '0;
				next_r.fa_q[i] = r.fa_raw[i];
			end else begin
				next_r.fa_cnt[i] = r.fa_cnt[i] + 22'h000001;
			end
		end
		// overload, active in drive and regeneration
		if (!(meas_in.motor_on || meas_in.regen)) begin
			next_r.ol = 1'b0;
		end else if (meas_in.current > r.ol_lvl) begin
			next_r.ol = 1'b1;
		end else if (meas_in.current < r.ol_lvl) begin
			next_r.ol = 1'b0;
		end
		next_r.od = pid_err > r.dev_lvl;
		// 0.1 s time base for terminal delays
		next_r.tick = 1'b0;
		if (r.tick_cnt >= 23'(TICK_CYC - 1)) begin
			next_r.tick_cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.tick_cnt = r.tick_cnt + 23'h000001;
		end
		// terminal on/off delay; pulses shorter than the delay vanish
		for (int i = 0; i < 2; i++) begin
			if (fn_val[i] == r.term[i]) begin
				next_r.t_cnt[i] = '0;
			end else if (r.t_cnt[i] >= (fn_val[i] ? r.on_dly[i] : r.off_dly[i])) begin
				next_r.t_cnt[i] = '0;
				next_r.term[i] = fn_val[i];
				irq_set[2 * i + (fn_val[i] ? 0 : 1)] = 1'b1;
			end else if (r.tick) begin
				next_r.t_cnt[i] = r.t_cnt[i] + 10'h001;
			end
		end
		// register writes, address decode
		if (wr_acc) begin
			if (apb_in.paddr == REG_TARGET) begin
				next_r.target = apb_in.pwdata[15:0];
			end else if (apb_in.paddr == REG_ACC_TH) begin
				next_r.acc_th = apb_in.pwdata[15:0];
			end else if (apb_in.paddr == REG_DEC_TH) begin
				next_r.dec_th = apb_in.pwdata[15:0];
			end else if (apb_in.paddr == REG_OL_LVL) begin
				next_r.ol_lvl = apb_in.pwdata[15:0];
			end else if (apb_in.paddr == REG_DEV_LVL) begin
				next_r.dev_lvl = apb_in.pwdata[15:0];
			end else if (apb_in.paddr == REG_SEL) begin
				next_r.sel[0] = apb_in.pwdata[2:0];
				next_r.sel[1] = apb_in.pwdata[SEL1_POS +: 3];
			end else if (apb_in.paddr == REG_DLY0 || apb_in.paddr == REG_DLY1) begin
				next_r.on_dly[apb_in.paddr[2]] = (apb_in.pwdata[9:0] > DLY_MAX) ?
					DLY_MAX : apb_in.pwdata[9:0];
				next_r.off_dly[apb_in.paddr[2]] = (apb_in.pwdata[DLY_OFF_POS +: 10] > DLY_MAX) ?
					DLY_MAX : apb_in.pwdata[DLY_OFF_POS +: 10];
			end else if (apb_in.paddr == REG_IRQ_ST) begin
				next_r.irq_st = r.irq_st & ~apb_in.pwdata[3:0];
			end else if (apb_in.paddr == REG_IRQ_MASK) begin
				next_r.irq_mask = apb_in.pwdata[3:0];
			end
		end
		// set wins over a same-cycle clear
		next_r.irq_st = next_r.irq_st | irq_set;
		// read data and error captured in the setup cycle
		if (rd_setup) begin
			next_r.pslverr = 1'b0;
			next_r.prdata = '0;
			if (apb_in.paddr == REG_TARGET) begin
				next_r.prdata[15:0] = r.target;
			end else if (apb_in.paddr == REG_ACC_TH) begin
				next_r.prdata[15:0] = r.acc_th;
			end else if (apb_in.paddr == REG_DEC_TH) begin
				next_r.prdata[15:0] = r.dec_th;
			end else if (apb_in.paddr == REG_OL_LVL) begin
				next_r.prdata[15:0] = r.ol_lvl;
			end else if (apb_in.paddr == REG_DEV_LVL) begin
				next_r.prdata[15:0] = r.dev_lvl;
			end else if (apb_in.paddr == REG_SEL) begin
				next_r.prdata[2:0] = r.sel[0];
				next_r.prdata[SEL1_POS +: 3] = r.sel[1];
			end else if (apb_in.paddr == REG_DLY0 || apb_in.paddr == REG_DLY1) begin
				next_r.prdata[9:0] = r.on_dly[apb_in.paddr[2]];
				next_r.prdata[DLY_OFF_POS +: 10] = r.off_dly[apb_in.paddr[2]];
			end else if (apb_in.paddr == REG_STAT) begin
				next_r.prdata[3:0] = {r.od, r.ol, r.fa_q};
				next_r.prdata[STAT_TERM_POS +: 2] = r.term;
			end else if (apb_in.paddr == REG_IRQ_ST) begin
				next_r.prdata[3:0] = r.irq_st;
			end else if (apb_in.paddr == REG_IRQ_MASK) begin
				next_r.prdata[3:0] = r.irq_mask;
			end else begin
				next_r.pslverr = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			r <= RST_STATE;
		end else begin
			r <= next_r;
		end
	end

	// outputs
	always_comb begin
		pready_out = apb_in.psel && apb_in.penable;
		prdata_out = r.prdata;
		pslverr_out = r.pslverr;
		status_n_out = ~r.term;
		irq_out = |(r.irq_st & r.irq_mask);
	end

	// arrival off while stopped or on a ramp
	AST_FA1_OFF_RAMP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.accel || meas_in.decel || !meas_in.motor_on) |=> !r.fa_raw[0])
		else $error("constant-speed arrival stayed on while ramping or stopped");

	// arrival on inside the lead band
	AST_FA1_ON_BAND: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && !meas_in.accel && !meas_in.decel && fa1_dist <= ARR_LEAD)
		|=> r.fa_raw[0])
		else $error("constant-speed arrival not on within the lead band");

	// arrival holds inside the hysteresis band
	AST_FA1_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && !meas_in.accel && !meas_in.decel && fa1_dist > ARR_LEAD
		&& fa1_dist <= ARR_LEAD + ARR_LAG) |=> (r.fa_raw[0] == $past(r.fa_raw[0])))
		else $error("arrival toggled inside the hysteresis band");

	// arrival off once the lag band is left
	AST_FA1_OFF_FAR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && !meas_in.accel && !meas_in.decel
		&& fa1_dist > ARR_LEAD + ARR_LAG) |=> !r.fa_raw[0])
		else $error("constant-speed arrival stayed on past the lag band");

	// over-frequency on from the accel threshold, acceleration included, not while decelerating
	AST_FA2_ON: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && !meas_in.decel
		&& 17'(meas_in.out_freq) + 17'(ARR_LEAD) >= 17'(r.acc_th)) |=> r.fa_raw[1])
		else $error("over-frequency not on above accel threshold");

	// over-frequency off below the decel threshold
	AST_FA2_OFF: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && !meas_in.accel && !meas_in.decel
		&& 17'(meas_in.out_freq) + 17'(ARR_LEAD) < 17'(r.acc_th)
		&& 17'(meas_in.out_freq) + 17'(ARR_LAG) < 17'(r.dec_th)) |=> !r.fa_raw[1])
		else $error("over-frequency not off below decel threshold");

	// over-frequency off whenever the motor output is off
	AST_FA2_STOP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!meas_in.motor_on |=> !r.fa_raw[1])
		else $error("over-frequency stayed on with the motor output off");

	// decelerating above the off point keeps the flag as it was
	AST_FA2_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && meas_in.decel
		&& 17'(meas_in.out_freq) + 17'(ARR_LAG) >= 17'(r.dec_th))
		|=> (r.fa_raw[1] == $past(r.fa_raw[1])))
		else $error("over-frequency toggled above the decel off point");

	// arrival flag follows its raw state only after the settle count
	AST_FA_SETTLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.fa_q[0] != $past(r.fa_q[0])) |-> ($past(r.fa_cnt[0]) == 22'(FA_DLY - 1)))
		else $error("arrival output changed before the settle time");

	// same settle rule for the over-frequency flag
	AST_FA2_SETTLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.fa_q[1] != $past(r.fa_q[1])) |-> ($past(r.fa_cnt[1]) == 22'(FA_DLY - 1)))
		else $error("over-frequency output changed before the settle time");

	// settle counters never pass their end point
	AST_FA_CNT_BOUND: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.fa_cnt[0] < 22'(FA_DLY)) && (r.fa_cnt[1] < 22'(FA_DLY)))
		else $error("arrival settle counter ran past its end");

	// overload seen during regeneration
	AST_OL_ON: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.regen && meas_in.current > r.ol_lvl) |=> r.ol)
		else $error("overload missed during regeneration");

	// overload seen while driving
	AST_OL_DRIVE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.motor_on && meas_in.current > r.ol_lvl) |=> r.ol)
		else $error("overload missed while driving");

	// overload off below the level
	AST_OL_OFF: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(meas_in.current < r.ol_lvl) |=> !r.ol)
		else $error("overload on below level");

	// no overload without drive or regeneration
	AST_OL_IDLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(!meas_in.motor_on && !meas_in.regen) |=> !r.ol)
		else $error("overload on with neither drive nor regeneration");

	// exactly at the level the warning keeps its state
	AST_OL_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		((meas_in.motor_on || meas_in.regen) && meas_in.current == r.ol_lvl)
		|=> (r.ol == $past(r.ol)))
		else $error("overload toggled at the exact level");

	// deviation on above its level
	AST_OD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(abs_diff(meas_in.setpoint, meas_in.feedback) > r.dev_lvl) |=> r.od)
		else $error("deviation not flagged");

	// deviation off at or below its level
	AST_OD_OFF: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(abs_diff(meas_in.setpoint, meas_in.feedback) <= r.dev_lvl) |=> !r.od)
		else $error("deviation flagged at or below level");

	// levels carry their defaults out of reset
	AST_RST_LVL: assert property (@(posedge core_clk_in)
		$fell(sys_rst_in) |-> (r.ol_lvl == OL_LVL_RST && r.dev_lvl == DEV_LVL_RST))
		else $error("levels wrong after reset");

	// first terminal follows its function at once with zero delays
	AST_TERM_NODLY: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.on_dly[0] == 10'h000 && r.off_dly[0] == 10'h000 && fn_val[0] != r.term[0])
		|=> (status_n_out[0] == !$past(fn_val[0])))
		else $error("terminal did not follow function with zero delay");

	// second terminal works on its own in the same way
	AST_TERM1_NODLY: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.on_dly[1] == 10'h000 && r.off_dly[1] == 10'h000 && fn_val[1] != r.term[1])
		|=> (status_n_out[1] == !$past(fn_val[1])))
		else $error("second terminal did not follow its function with zero delay");

	// terminal only moves when its function differs
	AST_TERM_STABLE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(fn_val[0] == r.term[0]) |=> $stable(r.term[0]))
		else $error("terminal moved without a function change");

	// terminal waits out its delay count
	AST_TERM_DLY_HOLD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(fn_val[0] != r.term[0] && r.t_cnt[0] < (fn_val[0] ? r.on_dly[0] : r.off_dly[0]))
		|=> $stable(r.term[0]))
		else $error("terminal changed before its delay ran out");

	// delay settings never exceed the limit
	AST_DLY_CLAMP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.on_dly[0] <= DLY_MAX && r.off_dly[0] <= DLY_MAX
		&& r.on_dly[1] <= DLY_MAX && r.off_dly[1] <= DLY_MAX))
		else $error("terminal delay setting above its limit");

	// time base ticks are single pulses
	AST_TICK_GAP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		r.tick |=> !r.tick)
		else $error("delay time base ticked twice in a row");

	// unassigned or unknown codes leave the terminal off
	AST_SEL_NONE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		(r.sel[0] == OPT_NONE || r.sel[0] > OPT_OD) |-> !fn_val[0])
		else $error("unassigned terminal carried a function");

	// both arrival functions on two terminals
	COV_BOTH_ARRIVAL: cover property (@(posedge core_clk_in)
		r.sel[0] == OPT_FA1 && r.sel[1] == OPT_FA2 && r.term == 2'b11);

	// overload carried to a terminal
	COV_OL_TERM: cover property (@(posedge core_clk_in) r.sel[0] == OPT_OL && r.term[0]);

	// deviation raising the interrupt
	COV_OD_IRQ: cover property (@(posedge core_clk_in) r.sel[1] == OPT_OD && irq_out);

	// terminal held on by its off delay
	COV_OFF_DELAY: cover property (@(posedge core_clk_in) r.off_dly[0] != 10'h000 && r.term[0] && !fn_val[0]);

	// overload while only regenerating
	COV_REGEN_OL: cover property (@(posedge core_clk_in) meas_in.regen && !meas_in.motor_on && r.ol);
endmodule

// ### logic/dso_pkg.sv
/*
 * Constants, register map and carrier types of the drive status-output block.
 * Assumes 50 MHz core clock; frequencies in 0.1 Hz, current and PID in 0.1 %.
 */
package dso_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned FA_DELAY_MS = 60;
	localparam int unsigned FA_DELAY_CYC = FA_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned DLY_TICK_MS = 100;
	localparam int unsigned DLY_TICK_CYC = DLY_TICK_MS * (CLK_HZ / 1000);
	localparam logic [15:0] ARR_LEAD = 16'h000F; // 1.5 Hz in 0.1 Hz
	localparam logic [15:0] ARR_LAG = 16'h0005; // 0.5 Hz in 0.1 Hz
	localparam logic [9:0] DLY_MAX = 10'h3E8; // 100.0 s in 0.1 s
	localparam logic [15:0] OL_LVL_RST = 16'h03E8; // 100.0 %
	localparam logic [15:0] DEV_LVL_RST = 16'h001E; // 3.0 %
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [15:0] ACC_TH_RST = 16'h0000;
	localparam logic [15:0] DEC_TH_RST = 16'h0000;
	localparam logic [7:0] REG_TARGET = 8'h00;
	localparam logic [7:0] REG_ACC_TH = 8'h04;
	localparam logic [7:0] REG_DEC_TH = 8'h08;
	localparam logic [7:0] REG_OL_LVL = 8'h0C;
	localparam logic [7:0] REG_DEV_LVL = 8'h10;
	localparam logic [7:0] REG_SEL = 8'h14;
	localparam logic [7:0] REG_DLY0 = 8'h18;
	localparam logic [7:0] REG_DLY1 = 8'h1C;
	localparam logic [7:0] REG_STAT = 8'h20;
	localparam logic [7:0] REG_IRQ_ST = 8'h24;
	localparam logic [7:0] REG_IRQ_MASK = 8'h28;
	localparam int SEL1_POS = 4;
	localparam int DLY_OFF_POS = 16;
	localparam int STAT_TERM_POS = 4;
	typedef enum logic [2:0] {
		OPT_NONE = 3'b000,
		OPT_FA1 = 3'b001,
		OPT_FA2 = 3'b010,
		OPT_OL = 3'b011,
		OPT_OD = 3'b100
	} dso_opt_e;
	typedef struct packed {
		logic [15:0] out_freq; // 0.1 Hz
		logic motor_on;
		logic accel;
		logic decel;
		logic regen;
		logic [15:0] current; // 0.1 % of rated
		logic [15:0] setpoint; // 0.1 %
		logic [15:0] feedback; // 0.1 %
	} dso_meas_s;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dso_apb_req_s;
endpackage

// ### dv/dso_machine.sv
/*
 * Far-side model: external machinery reading the two open-collector terminals.
 * Assumes a pull-up on each terminal wire; the block only ever pulls it low.
 */
`timescale 1ns/1ps
module dso_machine (
	input wire logic [1:0] status_n_in, // terminal drive, low pulls
	output logic [1:0] term_on_out // machinery sees function on
);
	logic [1:0] line;

	// pull-up wins while the transistor is off; on means pulled low
	assign line = status_n_in;
	assign term_on_out = ~line;
endmodule

// ### dv/dso_status_out_tb.sv
/*
 * Self-checking bench for the drive status-output block, APB tasks and sequences.
 * Assumes shortened FA_DLY and TICK_CYC, and the 0.1 Hz / 0.1 % input units.
 */
`timescale 1ns/1ps
module dso_status_out_tb;
	import dso_pkg::*;
	localparam int FA = 8;
	localparam int TK = 4;
	localparam int W = FA + 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dso_meas_s m = '0;
	dso_apb_req_s apb = '0;
	logic pready, pslverr, irq;
	logic [31:0] prdata;
	logic [1:0] st_n, term_on;
	int err_count = 0;
	int samples_checked = 0;

	// 50 MHz core clock
	always #10 clk = ~clk;

	dso_status_out #(.FA_DLY(FA), .TICK_CYC(TK)) u_dso_status_out (.core_clk_in(clk),
		.sys_rst_in(rst), .meas_in(m), .apb_in(apb), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .status_n_out(st_n), .irq_out(irq));
	dso_machine u_dso_machine (.status_n_in(st_n), .term_on_out(term_on));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one apb transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= w;
		apb.paddr <= a;
		apb.pwdata <= d;
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		r = prdata;
		e = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0, r, e);
		chk("rdata", r, x);
		chk("slverr", {31'h0, e}, {31'h0, xe});
	endtask

	// terminals at the pins and as the machinery sees them
	task automatic chkt(input logic [1:0] e);
		chk("term", {30'h0, st_n}, {30'h0, e});
		chk("far", {30'h0, term_on}, {30'h0, ~e});
	endtask

	task automatic step(input logic [15:0] f, input logic ac, input logic de, input logic [1:0] e);
		m.out_freq <= f;
		m.accel <= ac;
		m.decel <= de;
		cyc(W);
		chkt(e);
	endtask

	// main sequence
	initial begin
		cyc(4);
		rst <= 1'b0;
		@(posedge clk);
		rd(REG_OL_LVL, 32'h0000_03E8, 1'b0);
		rd(REG_DEV_LVL, 32'h0000_001E, 1'b0);
		rd(8'h30, 32'h0, 1'b1);
		chkt(2'b11);
		$display("test reset done");
		wr(REG_TARGET, 32'h0000_01F4);
		wr(REG_ACC_TH, 32'h0000_0258);
		wr(REG_DEC_TH, 32'h0000_0190);
		wr(REG_IRQ_MASK, 32'h0000_0001);
		wr(REG_SEL, 32'h0000_0021);
		m.motor_on <= 1'b1;
		step(16'h01E4, 1'b0, 1'b0, 2'b11);
		m.out_freq <= 16'h01E6;
		cyc(4);
		chkt(2'b11);
		cyc(W);
		chkt(2'b10);
		chk("irq", {31'h0, irq}, 32'h1);
		step(16'h0206, 1'b0, 1'b0, 2'b10);
		step(16'h0209, 1'b0, 1'b0, 2'b11);
		step(16'h0249, 1'b1, 1'b0, 2'b01);
		step(16'h018C, 1'b0, 1'b1, 2'b01);
		step(16'h018A, 1'b0, 1'b1, 2'b11);
		rd(REG_IRQ_ST, 32'h0000_000F, 1'b0);
		wr(REG_IRQ_ST, 32'h0000_0001);
		cyc(2);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(REG_IRQ_ST, 32'h0000_000E, 1'b0);
		wr(REG_IRQ_ST, 32'h0000_000E);
		wr(REG_STAT, 32'h0000_003F);
		rd(REG_STAT, 32'h0, 1'b0);
		rd(REG_IRQ_ST, 32'h0, 1'b0);
		$display("test arrival done");
		m.motor_on <= 1'b0;
		m.regen <= 1'b1;
		wr(REG_SEL, 32'h0000_0043);
		m.current <= 16'h03E9;
		cyc(W);
		chkt(2'b10);
		m.current <= 16'h03E8;
		cyc(W);
		chkt(2'b10);
		m.current <= 16'h03E7;
		cyc(W);
		chkt(2'b11);
		m.setpoint <= 16'h0064;
		m.feedback <= 16'h008C;
		cyc(W);
		chkt(2'b01);
		m.feedback <= 16'h0082;
		cyc(W);
		chkt(2'b11);
		$display("test overload deviation done");
		wr(REG_DLY0, 32'h0000_0003);
		m.current <= 16'h03E9;
		cyc(8);
		chkt(2'b11);
		cyc(W);
		chkt(2'b10);
		$display("test delay done");
		wr(REG_DLY0, 32'h0002_0000);
		m.current <= 16'h03E7;
		cyc(4);
		chkt(2'b10);
		cyc(W);
		chkt(2'b11);
		m.current <= 16'h03E9;
		cyc(W);
		chkt(2'b10);
		wr(REG_SEL, 32'h0000_0075);
		cyc(W);
		chkt(2'b11);
		$display("test off delay and unassigned done");
		complete_run();
	end

	// watchdog against a hang
	initial begin
		cyc(5000);
		err_count++;
		complete_run();
	end
endmodule
